// [design/spfm_regs.vh]
// Constants for the sensor pin function multiplexer.
`ifndef SPFM_REGS_VH
`define SPFM_REGS_VH
`define SPFM_RST_MIN_NS 100
`define SPFM_CLK_NS 40
`define SPFM_RST_MIN_CYC (( `SPFM_RST_MIN_NS + `SPFM_CLK_NS - 1) / `SPFM_CLK_NS)
`define SPFM_PB_SEL_GPIO 2'h0
`define SPFM_PB_SEL_TIMER 2'h1
`define SPFM_PB_SEL_ANALOG 2'h2
`define SPFM_RST_PULSE_CYC 4'h1
`endif

// [design/spfm_pin_mux.v]
// Pin function multiplexer for port A, port B and the reset pin.
//
// Function
// - With the serial interface enabled, client_serial_out drives port_a_bit3.
// - With the serial interface enabled, client_serial_in is taken from port_a_bit2.
// - With the serial interface enabled, port_a_bit1 is the serial clock from the host.
// - Port A pins 0 to 3 feed the matching keypad_wake_irq input bit.
// - A port A pulldown stays off unless that pin's wake capability is enabled.
// - Port B bit 0 selects GPIO, timer channel 0 or analog input three.
// - External reset starts only after the reset pin is low for 100 ns and then rises.
// - External reset sends the processor to its reset vector.
// - The reset pin is a debug-entry condition and has an internal pullup.
// - With the serial interface enabled, port_a_bit0 is the active-low chip select.
// - Port B bit 1 selects GPIO, timer channel 1 or analog input four.
`timescale 1ns/10ps
`include "spfm_regs.vh"
module spfm_pin_mux #(
   parameter RST_MIN_CYC = `SPFM_RST_MIN_CYC
) (
   input  wire       clk_sys,
   input  wire       reset_n,
   input  wire [3:0] pa_in,
   output wire [3:0] pa_out,
   output wire [3:0] pa_oe_n,
   output wire [3:0] pa_pulldown_en,
   input  wire [3:0] gpio_a_out,
   input  wire [3:0] gpio_a_dir_out,
   input  wire [3:0] gpio_a_pd_req,
   input  wire [3:0] wake_en,
   output wire [3:0] gpio_a_in,
   output wire [3:0] keypad_wake_irq,
   input  wire       spi_enable,
   input  wire       client_serial_out,
   input  wire       client_serial_oe,
   output wire       client_serial_in,
   output wire       spi_sclk,
   output wire       spi_cs_n,
   input  wire [1:0] pb_in,
   output wire [1:0] pb_out,
   output wire [1:0] pb_oe_n,
   output wire [1:0] pb_pullup_en,
   input  wire [1:0] pb0_sel,
   input  wire [1:0] pb1_sel,
   input  wire [1:0] gpio_b_out,
   input  wire [1:0] gpio_b_dir_out,
   input  wire [1:0] gpio_b_pu_req,
   input  wire [1:0] timer_ch_out,
   input  wire [1:0] timer_ch_oe,
   output wire [1:0] gpio_b_in,
   output wire [1:0] timer_ch_in,
   output wire       analog_input_three,
   output wire       analog_input_four,
   input  wire       rst_pin_in,
   output wire       rst_pin_pullup_en,
   input  wire       debug_req,
   output wire       ext_reset_pulse,
   output wire       fetch_reset_vector,
   output wire       background_debug_mode
);
   // Select codes at the width of the select ports.
   localparam [1:0] SEL_GPIO   = `SPFM_PB_SEL_GPIO;
   localparam [1:0] SEL_TIMER  = `SPFM_PB_SEL_TIMER;
   localparam [1:0] SEL_ANALOG = `SPFM_PB_SEL_ANALOG;

   // Minimum low run in clock samples, cut on purpose to the counter width.
   // The counter is eight bits wide, so a minimum above 255 samples cannot be expressed.
   localparam [7:0] MIN_LOW    = RST_MIN_CYC[7:0];

   // Reset pin recognition states, one-hot.
   localparam [2:0] ST_HIGH    = 3'h1;
   localparam [2:0] ST_LOW     = 3'h2;
   localparam [2:0] ST_ARMED   = 3'h4;

   // Recognition state, low-run counter and the registered outputs, each with its next value.
   reg  [2:0] state_q;
   reg  [2:0] state_d;
   reg  [7:0] low_cnt_q;
   reg  [7:0] low_cnt_d;
   reg        pulse_q;
   reg        pulse_d;
   reg        bdm_q;
   reg        bdm_d;

   // Decoded port B function per bit.
   wire [1:0] pb_is_gpio;
   wire [1:0] pb_is_timer;
   wire [1:0] pb_is_analog;

   // True when a select port carries the given code; shared by both port B bits.
   function sel_is;
      input [1:0] sel;
      input [1:0] code;
      begin
         sel_is = (sel == code);
      end
   endfunction

   // Port A bit 3 carries the serial output while the serial interface is enabled.
   // The serial unit owns the output enable then, so a deselected client can release the pin.
   assign pa_out[3]    = spi_enable ? client_serial_out : gpio_a_out[3];
   assign pa_oe_n[3]   = spi_enable ? ~client_serial_oe : ~gpio_a_dir_out[3];

   // Port A bits 0 to 2 are host-driven inputs while the serial interface is enabled.
   // Forcing them undriven avoids a fight with the host if software left them as outputs.
   assign pa_out[2:0]  = gpio_a_out[2:0];
   assign pa_oe_n[2:0] = spi_enable ? 3'h7 : ~gpio_a_dir_out[2:0];

   // Serial inputs. When disabled they idle at their inactive levels so the serial unit stays quiet.
   // A floating or toggling pin in GPIO use can then never look like a host transfer.
   assign client_serial_in = spi_enable ? pa_in[2] : 1'b0;
   assign spi_sclk         = spi_enable ? pa_in[1] : 1'b0;
   assign spi_cs_n         = spi_enable ? pa_in[0] : 1'b1;

   // General-purpose input always sees the pin, so software can read it in any mode.
   assign gpio_a_in        = pa_in;

   // Wake inputs follow the pins only where wake capability is enabled.
   assign keypad_wake_irq  = pa_in & wake_en;

   // Pulldowns are only allowed alongside wake capability; a stray request is ignored.
   assign pa_pulldown_en   = gpio_a_pd_req & wake_en;

   // Port B function decode, bit 0.
   assign pb_is_gpio[0]    = sel_is(pb0_sel, SEL_GPIO);
   assign pb_is_timer[0]   = sel_is(pb0_sel, SEL_TIMER);
   assign pb_is_analog[0]  = sel_is(pb0_sel, SEL_ANALOG);

   // Port B function decode, bit 1.
   assign pb_is_gpio[1]    = sel_is(pb1_sel, SEL_GPIO);
   assign pb_is_timer[1]   = sel_is(pb1_sel, SEL_TIMER);
   assign pb_is_analog[1]  = sel_is(pb1_sel, SEL_ANALOG);

   // Port B drive. The timer owns the pin in timer mode; otherwise GPIO data is offered.
   // Analog mode and the spare code keep the driver off so the pin is a pure input.
   assign pb_out[0]  = pb_is_timer[0] ? timer_ch_out[0] : gpio_b_out[0];
   assign pb_oe_n[0] = pb_is_timer[0] ? ~timer_ch_oe[0] : (pb_is_gpio[0] ? ~gpio_b_dir_out[0] : 1'b1);
   assign pb_out[1]  = pb_is_timer[1] ? timer_ch_out[1] : gpio_b_out[1];
   assign pb_oe_n[1] = pb_is_timer[1] ? ~timer_ch_oe[1] : (pb_is_gpio[1] ? ~gpio_b_dir_out[1] : 1'b1);

   // Pullup only in GPIO mode, so it never loads an analog input.
   assign pb_pullup_en[0] = pb_is_gpio[0] & gpio_b_pu_req[0];
   assign pb_pullup_en[1] = pb_is_gpio[1] & gpio_b_pu_req[1];

   // GPIO input always sees the pin; the timer and analog inputs are gated by their selects.
   // Gating keeps an unselected unit from seeing pin activity meant for another function.
   assign gpio_b_in          = pb_in;
   assign timer_ch_in[0]     = pb_is_timer[0] & pb_in[0];
   assign timer_ch_in[1]     = pb_is_timer[1] & pb_in[1];
   assign analog_input_three = pb_is_analog[0] & pb_in[0];
   assign analog_input_four  = pb_is_analog[1] & pb_in[1];

   // Reset pin is always pulled up so a floating pin reads inactive.
   assign rst_pin_pullup_en = 1'b1;

   // Reset pin recognition. Each clock sample of a low pin counts once; the run is long
   // enough once MIN_LOW samples were low, and the pulse follows the first high sample.
   // A shorter low run is dropped on release, so a glitch never resets the processor.
   // The pin is taken as synchronous, so no extra stage delays recognition.
   always @* begin
      state_d   = state_q;
      low_cnt_d = low_cnt_q;
      pulse_d   = 1'b0;
      bdm_d     = bdm_q;
      case (state_q)
         ST_HIGH: begin
            if (!rst_pin_in) begin
               low_cnt_d = 8'h01;
               if (low_cnt_d >= MIN_LOW) begin
                  state_d = ST_ARMED;
               end else begin
                  state_d = ST_LOW;
               end
            end
         end
         ST_LOW: begin
            if (rst_pin_in) begin
               // Released too early: the run is forgotten.
               state_d   = ST_HIGH;
               low_cnt_d = 8'h00;
            end else begin
               low_cnt_d = low_cnt_q + 8'h01;
               if (low_cnt_d >= MIN_LOW) begin
                  state_d = ST_ARMED;
               end
            end
         end
         ST_ARMED: begin
            // The counter stops here, so a pin held low for ever cannot wrap it.
            if (rst_pin_in) begin
               state_d   = ST_HIGH;
               low_cnt_d = 8'h00;
               pulse_d   = 1'b1;
               bdm_d     = debug_req;
            end
         end
         default: begin
            state_d   = ST_HIGH;
            low_cnt_d = 8'h00;
         end
      endcase
   end

   // Recognition registers. The debug level is kept until the next recognised reset or reset_n going low,
   // so the core can read it long after the one-cycle pulse has gone.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_q   <= ST_HIGH;
         low_cnt_q <= 8'h00;
         pulse_q   <= 1'b0;
         bdm_q     <= 1'b0;
      end else begin
         state_q   <= state_d;
         low_cnt_q <= low_cnt_d;
         pulse_q   <= pulse_d;
         bdm_q     <= bdm_d;
      end
   end

   // Reset and vector fetch share one pulse, so the core cannot see one without the other.
   assign ext_reset_pulse       = pulse_q;
   assign fetch_reset_vector    = pulse_q;
   assign background_debug_mode = bdm_q;
endmodule // spfm_pin_mux

// [verif/spfm_checker.sv]
// Port-level assertion checker for the sensor pin function multiplexer.
`timescale 1ns/10ps
module spfm_checker (
   input wire logic clk_sys, reset_n, spi_enable, client_serial_out, client_serial_in, spi_sclk, spi_cs_n,
   input wire logic ext_reset_pulse, fetch_reset_vector, rst_pin_in,
   input wire logic [3:0] pa_in, pa_out, wake_en, gpio_a_pd_req, pa_pulldown_en, keypad_wake_irq
);
   // Every check samples on the system clock and sleeps while reset is low.
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_sout; spi_enable |-> pa_out[3] == client_serial_out; endproperty
   a_sout: assert property (p_sout) else $error("serial out missing on pin 3");
   property p_sin; spi_enable |-> client_serial_in == pa_in[2]; endproperty
   a_sin: assert property (p_sin) else $error("serial in not from pin 2");
   property p_host; spi_enable |-> spi_sclk == pa_in[1] && spi_cs_n == pa_in[0]; endproperty
   a_host: assert property (p_host) else $error("serial clock or select wrong");
   property p_off; !spi_enable |-> spi_cs_n && !spi_sclk; endproperty
   a_off: assert property (p_off) else $error("serial inputs active while off");
   property p_kbi; keypad_wake_irq[3:1] == (pa_in[3:1] & wake_en[3:1]); endproperty
   a_kbi: assert property (p_kbi) else $error("wake input mismatch");
   property p_pd; pa_pulldown_en == (gpio_a_pd_req & wake_en); endproperty
   a_pd: assert property (p_pd) else $error("pulldown without wake enable");
   property p_rst; ext_reset_pulse |-> $past(rst_pin_in) && !$past(rst_pin_in, 2) && !$past(rst_pin_in, 3)
      && !$past(rst_pin_in, 4) ##1 !ext_reset_pulse; endproperty
   a_rst: assert property (p_rst) else $error("reset pulse without long low");
   property p_vec; fetch_reset_vector == ext_reset_pulse; endproperty
   a_vec: assert property (p_vec) else $error("vector fetch not tied to reset");
   // A few covers show the main scenarios were reached.
   cover property (ext_reset_pulse);
   cover property (spi_enable && !spi_cs_n);
   cover property (|pa_pulldown_en);
endmodule // spfm_checker
bind spfm_pin_mux spfm_checker i_chk (.*);

// [verif/spfm_host.sv]
// Behavioural external host that drives select, clock and data into port A.
`timescale 1ns/10ps
module spfm_host (
   input wire logic       clk_sys, active,
   input wire logic [2:0] pat,
   output logic     [2:0] pins = 3'h5
);
   // Released lines toggle each cycle so a stale level never passes for a driven one.
   always @(posedge clk_sys) pins <= active ? pat : ~pins;
endmodule // spfm_host

// [verif/spfm_pin_mux_test.sv]
// Self-checking testbench for the sensor pin function multiplexer.
`timescale 1ns/10ps
module spfm_pin_mux_test;
   logic clk_sys = '0, reset_n = '0, spi_enable = '0, client_serial_out = '0, client_serial_oe = '0, pa3 = '0;
   logic rst_pin_in = 1'b1, debug_req = '0, client_serial_in, spi_sclk, spi_cs_n, analog_input_three;
   logic analog_input_four, rst_pin_pullup_en, ext_reset_pulse, fetch_reset_vector, background_debug_mode;
   logic [3:0] gpio_a_out = '0, gpio_a_dir_out = '0, gpio_a_pd_req = '0, wake_en = '0, pulses = '0;
   logic [3:0] pa_out, pa_oe_n, pa_pulldown_en, gpio_a_in, keypad_wake_irq;
   logic [1:0] pb_in = '0, pb0_sel = '0, pb1_sel = '0, gpio_b_out = '0, gpio_b_dir_out = '0, gpio_b_pu_req = '0;
   logic [1:0] timer_ch_out = '0, timer_ch_oe = '0, pb_out, pb_oe_n, pb_pullup_en, gpio_b_in, timer_ch_in;
   logic [2:0] pat = '0;
   wire  [2:0] host_pins;
   wire  [3:0] pa_in = {pa3, host_pins};
   int num_errors = 0, cmp_count = 0;
   spfm_pin_mux #(.RST_MIN_CYC(3)) i_dut (.*);
   spfm_host i_host (.clk_sys(clk_sys), .active(spi_enable), .pat(pat), .pins(host_pins));
   always #20 clk_sys = ~clk_sys;
   // Reset pulses last one cycle, so they are counted rather than sampled once.
   always @(posedge clk_sys) if (ext_reset_pulse === 1'b1) pulses <= pulses + 4'h1;
   task automatic st(int n = 1); repeat (n) @(posedge clk_sys); #1; endtask
   task automatic ck(logic [3:0] g, e); cmp_count++;
      if (g !== e) begin num_errors++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end endtask
   task automatic finish_test; $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("verification passed"); else $display("verification failed"); $finish; endtask
   initial begin
      st(3); reset_n = 1'b1; spi_enable = 1'b1; gpio_a_out = 4'hF;
      for (int i = 0; i < 8; i++) begin pat = i[2:0]; client_serial_out = i[0]; client_serial_oe = i[1]; st(2);
         ck(pa_oe_n, {~i[1], 3'h7});
         ck(client_serial_in, pa_in[2]); ck(pa_out[3], i[0]);
         ck(spi_sclk, pa_in[1]); ck(spi_cs_n, pa_in[0]); end
      spi_enable = 1'b0; gpio_a_out = 4'h5; gpio_a_dir_out = 4'h6; gpio_a_pd_req = 4'hB; st; ck(pa_out, 4'h5);
      ck({spi_cs_n, spi_sclk}, 2'h2); ck(pa_oe_n, 4'h9); ck(gpio_a_in, pa_in);
      for (int i = 0; i < 16; i++) begin wake_en = i[3:0]; pa3 = i[1]; st; ck(pa_pulldown_en, 4'hB & i[3:0]);
         ck(keypad_wake_irq[3:1], pa_in[3:1] & i[3:1]); end
      pb_in = 2'h3; gpio_b_out = 2'h1; timer_ch_out = 2'h2; timer_ch_oe = 2'h3; gpio_b_dir_out = 2'h3; gpio_b_pu_req = 2'h2;
      for (int s = 0; s < 4; s++) begin pb0_sel = s[1:0]; pb1_sel = s[1:0]; st; ck(pb_pullup_en, s == 0 ? 2'h2 : 2'h0);
         ck({analog_input_four, analog_input_three, timer_ch_in}, s == 2 ? 4'hC : s == 1 ? 4'h3 : 4'h0);
         ck(pb_oe_n, s >= 2 ? 2'h3 : 2'h0); ck(gpio_b_in, 2'h3);
         ck(pb_out, s == 1 ? 2'h2 : 2'h1); end
      $display("test port muxing done"); debug_req = 1'b1; rst_pin_in = 1'b0; st(2); rst_pin_in = 1'b1; st(3); ck(pulses, 4'h0);
      rst_pin_in = 1'b0; st(3); rst_pin_in = 1'b1; st(3); ck(pulses, 4'h1); ck(background_debug_mode, 1'b1);
      ck(rst_pin_pullup_en, 1'b1); reset_n = 1'b0; st; reset_n = 1'b1; st; ck(background_debug_mode, 1'b0);
      ck(pulses, 4'h1); $display("test reset pin done"); finish_test;
   end
endmodule // spfm_pin_mux_test
